/* logic/supervisor_pkg.sv */
// Shared constants of the supply supervision block: register map, field
// positions, reset values and timing counts.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package supervisor_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ         = 25;
	localparam int RESCAN_US       = 32;                  // Longest delay before a persisting fault flags again
	localparam int RESCAN_CYCLES   = RESCAN_US * CLK_MHZ; // Longest time, so rounded down
	localparam int RESCAN_W        = 10;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_TEMPERATURE_RESULT  = 8'h00;
	localparam logic [7:0] OFS_COMMON_VOLTAGE_LOW  = 8'h04;
	localparam logic [7:0] OFS_COMMON_VOLTAGE_HIGH = 8'h08;
	localparam logic [7:0] OFS_IRQ_FLAGS_FIRST     = 8'h0c;
	localparam logic [7:0] OFS_IRQ_FLAGS_SECOND    = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK_FIRST      = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK_SECOND     = 8'h18;
	localparam logic [7:0] OFS_TEMPERATURE_CONTROL = 8'h1c;
	localparam logic [7:0] OFS_RAIL_CONTROL        = 8'h20;
	localparam logic [7:0] OFS_RAIL_STATUS         = 8'h24;

	// ==========================================================
	// Field positions
	localparam int BIT_VOLTAGE_MSB     = 0; // High register: bit 8 of the setting
	localparam int BIT_COMMIT_REQUEST  = 6; // High register: write 1 to commit
	localparam int BIT_CONV_REQUEST    = 7; // Temperature control: write 1 to convert
	localparam int BIT_CONV_DONE       = 5; // Temperature control: 0 while busy
	localparam int BIT_ACTIVE          = 0; // Rail control: write 1 to power up
	localparam int BIT_STANDBY         = 1; // Rail control: write 1 to power down
	localparam int BIT_FLAG_COMMIT     = 0; // First flags: commit done
	localparam int BIT_FLAG_SHUT_LO    = 1; // First flags [5:1]: shutdown faults
	localparam int BIT_FLAG_EOC        = 0; // Second flags: end of conversion
	localparam int BIT_FLAG_UV_LO      = 1; // Second flags [4:1]: regulator/pump undervoltage

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_MASK_FIRST  = 8'h3f;
	localparam logic [7:0] RST_MASK_SECOND = 8'h1f;
	localparam logic [8:0] RST_VOLTAGE     = 9'h000;

	// ==========================================================
	// Temperature conversion
	localparam logic [8:0] TEMP_OFFSET = 9'h00a;   // Code 0 maps to minus ten degrees
	localparam logic [7:0] TEMP_MIN    = 8'hf6;    // Minus ten degrees
	localparam logic [7:0] TEMP_MAX    = 8'h55;    // 85 degrees

	typedef enum logic [1:0] {
		RAILS_OFF,
		RAILS_ON,
		COMMIT_DRAIN,
		COMMIT_WRITE
	} rail_state_e;

endpackage

/* logic/conv_if.sv */
// Handshake between the supervisor core and the temperature converter.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	logic       start;  // One-cycle request
	logic       busy;   // High while a conversion runs
	logic       done;   // One-cycle pulse with a fresh result
	logic [7:0] result; // Two's complement degrees

	modport ctrl (output start, input busy, input done, input result);
	modport conv (input start, output busy, output done, output result);
endinterface
`default_nettype wire

/* logic/temp_converter.sv */
// Temperature converter: runs one analog conversion per request and reduces
// the 10-bit code to a saturated 8-bit degree value.
// Assumes the analog converter answers each start with one done pulse.
`timescale 1ns/1ps
`default_nettype none
module temp_converter
	import supervisor_pkg::*;
(
	// Clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RESET,
	// Core side
	conv_if.conv            bus,
	// Analog converter
	output logic            ADC_START,
	input  wire logic       ADC_DONE,
	input  wire logic [9:0] ADC_CODE
);

	typedef struct packed {
		logic       busy;
		logic       start;
		logic       done;
		logic [7:0] result;
	} conv_s;

	conv_s s_q;
	conv_s s_d;

	// ==========================================================
	// Code reduction, one degree per eight codes, clamped both ways
	function automatic logic [7:0] reduce(input logic [9:0] code);
		logic signed [8:0] t;
		t = $signed({2'b00, code[9:3]}) - $signed(TEMP_OFFSET);
		if (t <= $signed({TEMP_MIN[7], TEMP_MIN}))
			reduce = TEMP_MIN;
		else if (t >= $signed({1'b0, TEMP_MAX}))
			reduce = TEMP_MAX;
		else
			reduce = t[7:0];
	endfunction

	// ==========================================================
	// Conversion sequencing; a request while busy is ignored
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.done = 1'b0;
		if (bus.start && !s_q.busy) begin
			s_d.busy = 1'b1;
			s_d.start = 1'b1;
		end
		if (s_q.busy && ADC_DONE) begin
			s_d.busy = 1'b0;
			s_d.done = 1'b1;
			s_d.result = reduce(ADC_CODE);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign ADC_START  = s_q.start;
	assign bus.busy   = s_q.busy;
	assign bus.done   = s_q.done;
	assign bus.result = s_q.result;

endmodule
`default_nettype wire

/* logic/supply_supervisor.sv */
// Supply supervision core: rail control, fault flags and masking, open-drain
// interrupt and power-good pins, nonvolatile commit of the common voltage and
// host-started temperature conversion, all behind an APB register slave.
// Assumes all pins are synchronous to CLOCK and that an outside sequencer
// powers the rails down in the programmed order when the enable falls.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor
	import supervisor_pkg::*;
(
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Host pins
	input  wire logic        WAKE_PIN,
	input  wire logic        RAILS_ON_PIN,
	output logic             IRQ_OUT_N_O,
	output logic             IRQ_OUT_N_OE,
	output logic             RAILS_OK_OUT_O,
	output logic             RAILS_OK_OUT_OE,
	// Shutdown fault detectors
	input  wire logic        THERMAL_SHUTDOWN,
	input  wire logic        POSITIVE_BOOST_UNDERVOLTAGE,
	input  wire logic        INVERTING_CONVERTER_UNDERVOLTAGE,
	input  wire logic        INPUT_UNDERVOLTAGE_LOCKOUT,
	input  wire logic        COMMON_VOLTAGE_FAULT,
	// Non-shutdown undervoltage detectors
	input  wire logic        NEGATIVE_SOURCE_UNDERVOLTAGE,
	input  wire logic        POSITIVE_SOURCE_UNDERVOLTAGE,
	input  wire logic        NEGATIVE_GATE_UNDERVOLTAGE,
	input  wire logic        POSITIVE_GATE_UNDERVOLTAGE,
	// Rail sequencer
	input  wire logic [3:0]  RAILS_IN_REGULATION,
	input  wire logic        RAILS_ALL_OFF,
	output logic             RAILS_ENABLE,
	output logic             RAILS_IMMEDIATE_OFF,
	// Nonvolatile store
	input  wire logic [8:0]  NVM_STORED_VALUE,
	input  wire logic        NVM_WRITE_DONE,
	output logic             NVM_WRITE_STROBE,
	output logic [8:0]       NVM_WRITE_DATA,
	// Analog temperature converter
	input  wire logic        ADC_DONE,
	input  wire logic [9:0]  ADC_CODE,
	output logic             ADC_START
);

	import supervisor_pkg::*;

	typedef struct packed {
		rail_state_e          state;
		logic [8:0]           voltage;
		logic [7:0]           mask1;
		logic [7:0]           mask2;
		logic [7:0]           flags1;
		logic [7:0]           flags2;
		logic [7:0]           temp;
		logic                 lock;
		logic                 read1_seen;
		logic                 read2_seen;
		logic                 pin_q;
		logic [4:0]           shut_prev;
		logic [3:0]           uv_prev;
		logic [RESCAN_W-1:0]  scan_cnt;
		logic                 kill;
		logic                 nvm_strobe;
		logic                 conv_start;
		logic [31:0]          rdata;
		logic                 rerr;
	} core_s;

	core_s s_q;
	core_s s_d;

	conv_if conv ();

	logic [4:0] shut;
	logic [3:0] uv;
	logic       setup;
	logic       access;
	logic       scan_tick;
	logic       irq;
	logic       rails_ok;

	// ==========================================================
	// Register decode for the error answer; the read mux decodes with its own case
	function automatic logic mapped(input logic [7:0] a);
		unique case (a)
			OFS_TEMPERATURE_RESULT, OFS_COMMON_VOLTAGE_LOW, OFS_COMMON_VOLTAGE_HIGH,
			OFS_IRQ_FLAGS_FIRST, OFS_IRQ_FLAGS_SECOND, OFS_IRQ_MASK_FIRST,
			OFS_IRQ_MASK_SECOND, OFS_TEMPERATURE_CONTROL, OFS_RAIL_CONTROL,
			OFS_RAIL_STATUS: mapped = 1'b1;
			default:         mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] a, input core_s s, input logic busy);
		read_mux = 32'h0000_0000;
		unique case (a)
			OFS_TEMPERATURE_RESULT:  read_mux[7:0] = s.temp;
			OFS_COMMON_VOLTAGE_LOW:  read_mux[7:0] = s.voltage[7:0];
			OFS_COMMON_VOLTAGE_HIGH: read_mux[BIT_VOLTAGE_MSB] = s.voltage[8];
			OFS_IRQ_FLAGS_FIRST:     read_mux[7:0] = s.flags1;
			OFS_IRQ_FLAGS_SECOND:    read_mux[7:0] = s.flags2;
			OFS_IRQ_MASK_FIRST:      read_mux[7:0] = s.mask1;
			OFS_IRQ_MASK_SECOND:     read_mux[7:0] = s.mask2;
			OFS_TEMPERATURE_CONTROL: read_mux[BIT_CONV_DONE] = ~busy;
			OFS_RAIL_STATUS:         read_mux[3:0] = {s.lock, s.kill, s.state};
			default:                 read_mux = 32'h0000_0000;
		endcase
	endfunction

	// ==========================================================
	// Fault vectors in flag-bit order
	assign shut = {COMMON_VOLTAGE_FAULT, INPUT_UNDERVOLTAGE_LOCKOUT, INVERTING_CONVERTER_UNDERVOLTAGE,
	               POSITIVE_BOOST_UNDERVOLTAGE, THERMAL_SHUTDOWN};
	assign uv   = {POSITIVE_GATE_UNDERVOLTAGE, NEGATIVE_GATE_UNDERVOLTAGE,
	               POSITIVE_SOURCE_UNDERVOLTAGE, NEGATIVE_SOURCE_UNDERVOLTAGE};

	assign setup     = PSEL && !PENABLE;
	assign access    = PSEL && PENABLE;
	assign scan_tick = (s_q.scan_cnt == RESCAN_W'(RESCAN_CYCLES - 1));

	// ==========================================================
	// Next-state logic for the whole core
	always_comb begin
		logic up_req;
		logic down_req;
		logic commit_req;
		logic wr;
		logic [7:0] clr1;
		logic [7:0] clr2;
		logic [7:0] set1;
		logic [7:0] set2;
		up_req = 1'b0;
		down_req = 1'b0;
		commit_req = 1'b0;
		wr = access && PWRITE && WAKE_PIN;
		clr1 = 8'h00;
		clr2 = 8'h00;
		set1 = 8'h00;
		set2 = 8'h00;
		s_d = s_q;
		s_d.nvm_strobe = 1'b0;
		s_d.conv_start = 1'b0;
		s_d.pin_q = RAILS_ON_PIN;
		s_d.shut_prev = shut;
		s_d.uv_prev = uv;
		s_d.scan_cnt = scan_tick ? '0 : s_q.scan_cnt + RESCAN_W'(1);

		// Read data captured in the setup cycle, so the access edge clears
		// exactly the bits the host is shown
		if (setup) begin
			s_d.rdata = WAKE_PIN ? read_mux(PADDR, s_q, conv.busy) : 32'h0000_0000;
			s_d.rerr = !WAKE_PIN || !mapped(PADDR);
		end
		if (access && !PWRITE && WAKE_PIN) begin
			if (PADDR == OFS_IRQ_FLAGS_FIRST) begin
				clr1 = s_q.rdata[7:0];
				s_d.read1_seen = 1'b1;
			end
			if (PADDR == OFS_IRQ_FLAGS_SECOND) begin
				clr2 = s_q.rdata[7:0];
				s_d.read2_seen = 1'b1;
			end
		end

		// Register writes
		if (wr) begin
			unique case (PADDR)
				OFS_COMMON_VOLTAGE_LOW:  s_d.voltage[7:0] = PWDATA[7:0];
				OFS_COMMON_VOLTAGE_HIGH: begin
					s_d.voltage[8] = PWDATA[BIT_VOLTAGE_MSB];
					commit_req = PWDATA[BIT_COMMIT_REQUEST];
				end
				OFS_IRQ_MASK_FIRST:      s_d.mask1 = PWDATA[7:0];
				OFS_IRQ_MASK_SECOND:     s_d.mask2 = PWDATA[7:0];
				OFS_TEMPERATURE_CONTROL: s_d.conv_start = PWDATA[BIT_CONV_REQUEST];
				OFS_RAIL_CONTROL: begin
					up_req = PWDATA[BIT_ACTIVE];
					down_req = PWDATA[BIT_STANDBY];
				end
				default: ;
			endcase
		end

		// The power-up pin acts on its edges only
		if (RAILS_ON_PIN && !s_q.pin_q)
			up_req = 1'b1;
		if (!RAILS_ON_PIN && s_q.pin_q)
			down_req = 1'b1;

		// Both flag registers read releases the restart lock
		if (s_d.read1_seen && s_d.read2_seen) begin
			s_d.lock = 1'b0;
			s_d.read1_seen = 1'b0;
			s_d.read2_seen = 1'b0;
		end

		// Faults flag on their rise and again on each rescan tick while held
		set1[BIT_FLAG_SHUT_LO +: 5] = shut & (~s_q.shut_prev | {5{scan_tick}});
		set2[BIT_FLAG_UV_LO +: 4] = uv & (~s_q.uv_prev | {4{scan_tick}});
		if (conv.done) begin
			s_d.temp = conv.result;
			set2[BIT_FLAG_EOC] = 1'b1;
		end
		if (|shut) begin
			s_d.lock = 1'b1;
			s_d.read1_seen = 1'b0;
			s_d.read2_seen = 1'b0;
		end
		if (COMMON_VOLTAGE_FAULT)
			s_d.kill = 1'b1;
		else if (RAILS_ALL_OFF)
			s_d.kill = 1'b0;

		// Rail state machine
		unique case (s_q.state)
			RAILS_OFF: begin
				if (commit_req)
					s_d.state = COMMIT_DRAIN;
				else if (up_req && !s_q.lock && !(|shut))
					s_d.state = RAILS_ON;
			end
			RAILS_ON: begin
				if (commit_req)
					s_d.state = COMMIT_DRAIN;
				else if (|shut || down_req)
					s_d.state = RAILS_OFF;
			end
			COMMIT_DRAIN: begin
				// Store only once every rail is down
				if (RAILS_ALL_OFF) begin
					s_d.nvm_strobe = 1'b1;
					s_d.state = COMMIT_WRITE;
				end
			end
			COMMIT_WRITE: begin
				if (NVM_WRITE_DONE) begin
					set1[BIT_FLAG_COMMIT] = 1'b1;
					s_d.state = RAILS_OFF;
				end
			end
		endcase

		// A set in the same cycle as a clearing read wins
		s_d.flags1 = (s_q.flags1 & ~clr1) | set1;
		s_d.flags2 = (s_q.flags2 & ~clr2) | set2;

		// Wake low is the sleep state: everything back to defaults and the
		// setting reloaded from the store, which is how a commit is checked
		if (!WAKE_PIN) begin
			s_d = '0;
			s_d.state = RAILS_OFF;
			s_d.mask1 = RST_MASK_FIRST;
			s_d.mask2 = RST_MASK_SECOND;
			s_d.voltage = NVM_STORED_VALUE;
			s_d.pin_q = RAILS_ON_PIN;
			s_d.rerr = setup || s_q.rerr; // A setup while asleep is always refused
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			s_q <= '0;
			s_q.state <= RAILS_OFF;
			s_q.mask1 <= RST_MASK_FIRST;
			s_q.mask2 <= RST_MASK_SECOND;
			s_q.voltage <= RST_VOLTAGE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Temperature converter; held in reset while asleep
	temp_converter u_conv (
		.CLOCK    (CLOCK),
		.RESET    (RESET || !WAKE_PIN),
		.bus      (conv.conv),
		.ADC_START(ADC_START),
		.ADC_DONE (ADC_DONE),
		.ADC_CODE (ADC_CODE)
	);
	assign conv.start = s_q.conv_start;

	// ==========================================================
	// Pins; masks only gate the interrupt, flags are untouched by them
	assign irq = |(s_q.flags1 & s_q.mask1) || |(s_q.flags2 & s_q.mask2);
	assign rails_ok = (s_q.state == RAILS_ON) && (&RAILS_IN_REGULATION)
	                  && !(|uv) && !(|shut);

	assign IRQ_OUT_N_O     = 1'b0;
	assign IRQ_OUT_N_OE    = irq;
	assign RAILS_OK_OUT_O  = 1'b0;
	assign RAILS_OK_OUT_OE = !rails_ok;

	// Rails follow the state; the sequencer applies the down order on the fall
	assign RAILS_ENABLE        = (s_q.state == RAILS_ON);
	assign RAILS_IMMEDIATE_OFF = s_q.kill;
	assign NVM_WRITE_STROBE    = s_q.nvm_strobe;
	assign NVM_WRITE_DATA      = s_q.voltage;

	// ==========================================================
	// Bus answer: zero wait states, data from the setup-cycle capture
	assign PREADY  = 1'b1;
	assign PRDATA  = s_q.rdata;
	assign PSLVERR = access && s_q.rerr;

endmodule
`default_nettype wire

/* tb/supervisor_monitor.sv */
// Checker for the supply supervisor, seeing only its top-level pins.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module supervisor_monitor
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RESET,
	// Register bus
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PSLVERR,
	// Pins and analog side
	input wire logic        WAKE_PIN,
	input wire logic        IRQ_OUT_N_OE,
	input wire logic        RAILS_OK_OUT_OE,
	input wire logic        THERMAL_SHUTDOWN,
	input wire logic        INPUT_UNDERVOLTAGE_LOCKOUT,
	input wire logic        COMMON_VOLTAGE_FAULT,
	input wire logic        NEGATIVE_SOURCE_UNDERVOLTAGE,
	input wire logic [3:0]  RAILS_IN_REGULATION,
	input wire logic        RAILS_ALL_OFF,
	input wire logic        RAILS_ENABLE,
	input wire logic        RAILS_IMMEDIATE_OFF,
	input wire logic        NVM_WRITE_DONE,
	input wire logic        NVM_WRITE_STROBE,
	input wire logic        ADC_START
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	logic       shut;
	logic [9:0] wait_q;
	logic [9:0] wait_d;
	// =========================================
	// Helpers
	assign shut = THERMAL_SHUTDOWN | INPUT_UNDERVOLTAGE_LOCKOUT | COMMON_VOLTAGE_FAULT;
	// Cycles a held thermal fault goes unsignalled; too long to unroll
	always_comb wait_d = (THERMAL_SHUTDOWN && !IRQ_OUT_N_OE) ? wait_q + 10'h001 : 10'h000;
	always_ff @(posedge CLOCK) wait_q <= RESET ? 10'h000 : wait_d;
	sequence bus_access;
		PSEL && PENABLE;
	endsequence
	sequence conv_write;
		bus_access ##0 PWRITE && PADDR == OFS_TEMPERATURE_CONTROL && PWDATA[BIT_CONV_REQUEST] && WAKE_PIN;
	endsequence
	// =========================================
	// Assertions
	fault_stops_rails_a: assert property ($rose(shut) |=> !RAILS_ENABLE)
		else $error("rails stay enabled after a shutdown fault");
	vcom_kill_a: assert property ($rose(COMMON_VOLTAGE_FAULT) |=> RAILS_IMMEDIATE_OFF)
		else $error("no immediate rail kill on common voltage fault");
	fault_pins_low_a: assert property ($rose(THERMAL_SHUTDOWN) |=> RAILS_OK_OUT_OE ##[0:1] IRQ_OUT_N_OE)
		else $error("pins not pulled low after thermal fault");
	pg_needs_reg_a: assert property (RAILS_IN_REGULATION != 4'hf |-> RAILS_OK_OUT_OE)
		else $error("power good released without regulation");
	uv_keeps_rails_a: assert property ($rose(NEGATIVE_SOURCE_UNDERVOLTAGE) && RAILS_ENABLE && !shut |=> RAILS_ENABLE[*3])
		else $error("regulator undervoltage shut the rails");
	commit_irq_a: assert property ($rose(NVM_WRITE_DONE) |-> ##[1:2] IRQ_OUT_N_OE)
		else $error("no interrupt after store finished");
	store_after_off_a: assert property (NVM_WRITE_STROBE |-> !RAILS_ENABLE && $past(RAILS_ALL_OFF))
		else $error("store started with rails not down");
	rescan_bound_a: assert property (wait_q <= RESCAN_CYCLES + 4)
		else $error("persisting fault not flagged again in time");
	conv_start_a: assert property (conv_write |-> ##[1:3] ADC_START)
		else $error("conversion request did not start converter");
	sleep_refuse_a: assert property (bus_access |-> WAKE_PIN || (PSLVERR && PRDATA == 32'h0))
		else $error("bus answered while asleep");
endmodule
`default_nettype wire

/* tb/plant_model.sv */
// Model of the analog side: rail sequencer, nonvolatile store, converter.
// Assumes the bench supplies the code to convert and the regulation state.
`timescale 1ns/1ps
`default_nettype none
module plant_model (
	// Clock
	input  wire logic       clock,
	// Rail sequencer side
	input  wire logic       rails_enable,
	input  wire logic       regulate,
	output logic [3:0]      in_regulation,
	output logic            all_off,
	// Store side
	input  wire logic       store_strobe,
	input  wire logic [8:0] store_data,
	output logic            store_done,
	output logic [8:0]      stored,
	// Converter side
	input  wire logic       adc_start,
	input  wire logic [9:0] code,
	output logic            adc_done,
	output logic [9:0]      adc_code
);
	int off_cnt = 0;
	int nvm_cnt = 0;
	int adc_cnt = 0;
	initial begin
		in_regulation = 4'h0;
		all_off = 1'b1;
		store_done = 1'b0;
		stored = 9'h000;
		adc_done = 1'b0;
		adc_code = 10'h000;
	end
	// =========================================
	// Slow answers; code lines toggle outside the done pulse
	always @(posedge clock) begin
		in_regulation <= (rails_enable && regulate) ? 4'hf : 4'h0;
		off_cnt = rails_enable ? 0 : (off_cnt < 6 ? off_cnt + 1 : 6);
		all_off <= (off_cnt >= 6);
		store_done <= (nvm_cnt == 1);
		if (store_strobe) begin
			nvm_cnt = 20;
			stored <= store_data;
		end else if (nvm_cnt > 0)
			nvm_cnt = nvm_cnt - 1;
		adc_done <= (adc_cnt == 1);
		adc_code <= (adc_cnt == 1) ? code : ~adc_code;
		if (adc_start)
			adc_cnt = 12;
		else if (adc_cnt > 0)
			adc_cnt = adc_cnt - 1;
	end
endmodule
`default_nettype wire

/* tb/pmic_fault_interrupt_monitor_test.sv */
// Self-checking bench for the supply supervisor over APB.
// Assumes the plant model on the analog side and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module pmic_fault_interrupt_monitor_test;
	import supervisor_pkg::*;
	logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic wake = 1'b1, rails_on = 1'b0, thermal = 1'b0, input_undervoltage_lockout = 1'b0, cvf = 1'b0, nsrc_uv = 1'b0;
	logic regulate = 1'b0, pready, pslverr, last_err, irq_o, irq_oe, ok_o, ok_oe, rails_en, kill;
	logic store_strobe, store_done, adc_start, adc_done, all_off;
	logic [8:0] store_data, stored;
	logic [9:0] code = 10'h000, adc_code;
	logic [3:0] in_reg;
	int num_errors = 0;
	int comparisons = 0;
	supply_supervisor supply_supervisor_i (.CLOCK(clock), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .WAKE_PIN(wake), .RAILS_ON_PIN(rails_on),
		.IRQ_OUT_N_O(irq_o), .IRQ_OUT_N_OE(irq_oe), .RAILS_OK_OUT_O(ok_o), .RAILS_OK_OUT_OE(ok_oe),
		.THERMAL_SHUTDOWN(thermal), .POSITIVE_BOOST_UNDERVOLTAGE(1'b0),
		.INVERTING_CONVERTER_UNDERVOLTAGE(1'b0), .INPUT_UNDERVOLTAGE_LOCKOUT(input_undervoltage_lockout),
		.COMMON_VOLTAGE_FAULT(cvf), .NEGATIVE_SOURCE_UNDERVOLTAGE(nsrc_uv),
		.POSITIVE_SOURCE_UNDERVOLTAGE(1'b0), .NEGATIVE_GATE_UNDERVOLTAGE(1'b0),
		.POSITIVE_GATE_UNDERVOLTAGE(1'b0), .RAILS_IN_REGULATION(in_reg), .RAILS_ALL_OFF(all_off),
		.RAILS_ENABLE(rails_en), .RAILS_IMMEDIATE_OFF(kill), .NVM_STORED_VALUE(stored),
		.NVM_WRITE_DONE(store_done), .NVM_WRITE_STROBE(store_strobe), .NVM_WRITE_DATA(store_data),
		.ADC_DONE(adc_done), .ADC_CODE(adc_code), .ADC_START(adc_start));
	plant_model plant_model_i (.clock(clock), .rails_enable(rails_en), .regulate(regulate),
		.in_regulation(in_reg), .all_off(all_off), .store_strobe(store_strobe),
		.store_data(store_data), .store_done(store_done), .stored(stored),
		.adc_start(adc_start), .code(code), .adc_done(adc_done), .adc_code(adc_code));
	always #20 clock = ~clock;
	// =========================================
	// Shared tasks
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// One transfer; the request stands until pready is seen at an edge
	task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= addr;
		pwdata <= data;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [7:0] addr);
		apb(1'b0, addr, 32'h0);
	endtask
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask
	// Bounded wait on rails enable (sel 0) or interrupt drive (sel 1)
	task automatic wait_for(input logic sel, input logic lvl);
		int n;
		for (n = 0; n < 1000 && (sel ? irq_oe : rails_en) !== lvl; n++)
			@(posedge clock);
		#1;
		if (n >= 1000) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic toggle();
		rails_on <= 1'b0;
		cyc(3);
		rails_on <= 1'b1;
		cyc(3);
	endtask
	// =========================================
	// Scenarios
	task automatic test_reset();
		rd(OFS_IRQ_MASK_FIRST);
		check(q, 32'h3f);
		rd(OFS_IRQ_MASK_SECOND);
		check(q, 32'h1f);
		rd(8'h28);
		check({q[30:0], last_err}, 32'h1);
		check({irq_o, ok_o, irq_oe, ok_oe}, 4'b0001);
		$display("reset values done");
	endtask
	task automatic test_rails();
		regulate <= 1'b1;
		rails_on <= 1'b1;
		wait_for(1'b0, 1'b1);
		cyc(4);
		check(ok_oe, 1'b0);
		nsrc_uv <= 1'b1;
		cyc(3);
		check({ok_oe, irq_oe, rails_en}, 3'b111);
		rd(OFS_IRQ_FLAGS_SECOND);
		check(q & 32'h2, 32'h2);
		nsrc_uv <= 1'b0;
		cyc(2);
		rd(OFS_IRQ_FLAGS_SECOND);
		cyc(3);
		check({ok_oe, irq_oe}, 2'b00);
		$display("rails and undervoltage done");
	endtask
	task automatic test_fault();
		thermal <= 1'b1;
		cyc(3);
		check({rails_en, ok_oe, irq_oe}, 3'b011);
		rd(OFS_IRQ_FLAGS_FIRST);
		check(q & 32'h2, 32'h2);
		wait_for(1'b1, 1'b1);
		thermal <= 1'b0;
		rd(OFS_IRQ_FLAGS_FIRST);
		toggle();
		check(rails_en, 1'b0);
		rd(OFS_IRQ_FLAGS_SECOND);
		toggle();
		wait_for(1'b0, 1'b1);
		cvf <= 1'b1;
		cyc(2);
		check({kill, rails_en}, 2'b10);
		cvf <= 1'b0;
		rd(OFS_IRQ_FLAGS_FIRST);
		check(q & 32'h20, 32'h20);
		rd(OFS_IRQ_FLAGS_SECOND);
		$display("shutdown faults done");
	endtask
	task automatic test_commit();
		wr(OFS_COMMON_VOLTAGE_LOW, 32'ha5);
		wr(OFS_COMMON_VOLTAGE_HIGH, 32'h41);
		wait_for(1'b1, 1'b1);
		check({23'h0, stored}, 32'h1a5);
		check(rails_en, 1'b0);
		rd(OFS_IRQ_FLAGS_FIRST);
		check(q & 32'h1, 32'h1);
		wr(OFS_COMMON_VOLTAGE_LOW, 32'h0);
		wr(OFS_COMMON_VOLTAGE_HIGH, 32'h0);
		wake <= 1'b0;
		rd(OFS_COMMON_VOLTAGE_LOW);
		check({q[30:0], last_err}, 32'h1);
		wake <= 1'b1;
		rd(OFS_COMMON_VOLTAGE_LOW);
		check(q, 32'ha5);
		rd(OFS_COMMON_VOLTAGE_HIGH);
		check(q & 32'h1, 32'h1);
		$display("store and wake done");
	endtask
	task automatic test_mask();
		wr(OFS_IRQ_MASK_FIRST, 32'h0);
		input_undervoltage_lockout <= 1'b1;
		cyc(4);
		check(irq_oe, 1'b0);
		rd(OFS_IRQ_FLAGS_FIRST);
		check(q & 32'h10, 32'h10);
		input_undervoltage_lockout <= 1'b0;
		cyc(2);
		rd(OFS_IRQ_FLAGS_FIRST);
		rd(OFS_IRQ_FLAGS_SECOND);
		wr(OFS_IRQ_MASK_FIRST, 32'h3f);
		cyc(2);
		check(irq_oe, 1'b0);
		$display("masking done");
	endtask
	task automatic test_temp();
		logic [9:0] codes [4] = '{10'h000, 10'h050, 10'h2f0, 10'h300};
		logic [7:0] temps [4] = '{8'hf6, 8'h00, 8'h54, 8'h55};
		int n;
		for (int i = 0; i < 4; i++) begin
			code <= codes[i];
			wr(OFS_TEMPERATURE_CONTROL, 32'h80);
			cyc(3);
			rd(OFS_TEMPERATURE_CONTROL);
			check(q & 32'h20, 32'h0);
			n = 0;
			do begin
				rd(OFS_TEMPERATURE_CONTROL);
				n++;
			end while (q[5] !== 1'b1 && n < 40);
			check(q & 32'h20, 32'h20);
			rd(OFS_TEMPERATURE_RESULT);
			check(q & 32'hff, {24'h0, temps[i]});
			rd(OFS_IRQ_FLAGS_SECOND);
			check(q & 32'h1, 32'h1);
		end
		$display("temperature done");
	endtask
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		test_reset();
		test_rails();
		test_fault();
		test_commit();
		test_mask();
		test_temp();
		end_of_test();
	end
endmodule
bind supply_supervisor supervisor_monitor supervisor_monitor_i (.CLOCK(CLOCK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .WAKE_PIN(WAKE_PIN), .IRQ_OUT_N_OE(IRQ_OUT_N_OE),
	.RAILS_OK_OUT_OE(RAILS_OK_OUT_OE), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
	.INPUT_UNDERVOLTAGE_LOCKOUT(INPUT_UNDERVOLTAGE_LOCKOUT), .COMMON_VOLTAGE_FAULT(COMMON_VOLTAGE_FAULT),
	.NEGATIVE_SOURCE_UNDERVOLTAGE(NEGATIVE_SOURCE_UNDERVOLTAGE), .RAILS_IN_REGULATION(RAILS_IN_REGULATION),
	.RAILS_ALL_OFF(RAILS_ALL_OFF), .RAILS_ENABLE(RAILS_ENABLE), .RAILS_IMMEDIATE_OFF(RAILS_IMMEDIATE_OFF),
	.NVM_WRITE_DONE(NVM_WRITE_DONE), .NVM_WRITE_STROBE(NVM_WRITE_STROBE), .ADC_START(ADC_START));
`default_nettype wire
